// ==== core/cidfs_seq.sv ====
// Caller-ID message sequencer: register port, message memory and the
// phase machine that drives the serial bit stream to one of four channels.
// Assumes a bit-level modulator downstream samples o_fsk_bit when active.
`timescale 1ns/1ps
`include "cidfs_defs.svh"

// Behaviour
// - Between message bytes insert flag_bit_count one-bits; zero inserts none.
// - Byte count above 64 behaves as exactly 64.
// - Byte count zero sends no data bytes.
// - Seizure sends twice seizure_half_count zero-one pairs; zero sends none.
// - Mark phase sends mark_bit_count one-bits; zero sends none.
// - Two-bit select routes the stream to channel one to four.
// - Generator-on enables the block; reset leaves it disabled.
// - Standard select picks first standard at 0, alternative at 1.
// - Trailing-mark off: output mutes after the last byte.
// - Trailing-mark on: continuous ones after the last byte until stopped.
// - Writing trailing-mark 0 with start 1 stops a trailing stream.
// - Start begins sending and clears itself when all data is sent.
// - With all counts zero, start clears right after being set.
module cidfs_seq #(
	parameter int BIT_CYCLES = `CIDFS_BIT_CYCLES,
	parameter int MAX_BYTES  = `CIDFS_MAX_BYTES
) (
	input  wire logic                         i_core_clk,  // 20 MHz clock
	input  wire logic                         i_resetn,    // Async reset, low
	input  wire logic                         i_reg_valid, // Command strobe
	input  wire logic [7:0]                   i_reg_cmd,   // Command byte
	input  wire logic [7:0]                   i_reg_wdata, // Register data
	output logic [7:0]                        o_reg_rdata, // Read data
	output logic                              o_reg_rvalid,// Read valid
	input  wire logic                         i_mem_wr,    // Memory write
	input  wire logic [$clog2(MAX_BYTES)-1:0] i_mem_addr,  // Memory address
	input  wire logic [7:0]                   i_mem_wdata, // Memory byte
	output logic                              o_fsk_bit,   // Serial bit
	output logic                              o_fsk_active,// Not muted
	output logic [3:0]                        o_chan_en,   // Channel route
	output logic                              o_std_select,// Standard pick
	output logic                              o_busy       // Start bit
);
	localparam int AW = $clog2(MAX_BYTES);

	cidfs_pkg::cidfs_cfg_t   cfg;
	cidfs_pkg::cidfs_state_t state_q;
	cidfs_pkg::cidfs_state_t state_d;
	logic                    ctrl_wr;
	logic                    start_q;
	logic [15:0]             tick_cnt_q;
	logic                    tick;
	logic [9:0]              cnt_q;
	logic [AW-1:0]           byte_q;
	logic [AW-1:0]           byte_d;
	logic [7:0]              rd_byte;
	logic [6:0]              eff_len;
	logic [9:0]              seize_bits;
	logic                    phase_end;
	logic                    launch;
	logic                    finish;
	logic                    stop_req;
	logic                    cur_bit;

	// Register port and message memory
	cidfs_reg_port u_regs (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_valid    (i_reg_valid),
		.i_cmd      (i_reg_cmd),
		.i_wdata    (i_reg_wdata),
		.i_start    (start_q),
		.o_cfg      (cfg),
		.o_ctrl_wr  (ctrl_wr),
		.o_rdata    (o_reg_rdata),
		.o_rvalid   (o_reg_rvalid)
	);

	cidfs_msg_mem #(.DEPTH(MAX_BYTES)) u_mem (
		.i_core_clk (i_core_clk),
		.i_wr       (i_mem_wr),
		.i_waddr    (i_mem_addr),
		.i_wdata    (i_mem_wdata),
		.i_raddr    (byte_q),
		.o_rdata    (rd_byte)
	);

	// Effective lengths
	assign eff_len = (cfg.message_byte_count > 8'(MAX_BYTES)) ?
		7'(MAX_BYTES) : cfg.message_byte_count[6:0];
	assign seize_bits = {cfg.seizure_half_count, 2'b00};

	// Stop request only honoured during the trailing stream
	assign stop_req = ctrl_wr && i_reg_wdata[`CIDFS_CTRL_START] &&
		!i_reg_wdata[`CIDFS_CTRL_TRAIL];

	// Bit clock: free count within any active phase
	assign tick = (state_q != cidfs_pkg::CIDFS_IDLE) &&
		(tick_cnt_q == 16'(BIT_CYCLES - 1));

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tick_cnt_q <= 16'h0000;
		end else if (state_q == cidfs_pkg::CIDFS_IDLE || tick) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	// End of the current phase, judged on the last bit of it
	always_comb begin
		phase_end = 1'b0;
		unique case (state_q)
			cidfs_pkg::CIDFS_SEIZE: phase_end = tick &&
				(cnt_q == seize_bits - 10'h001);
			cidfs_pkg::CIDFS_MARK:  phase_end = tick &&
				(cnt_q == {2'b00, cfg.mark_bit_count} - 10'h001);
			cidfs_pkg::CIDFS_DATA:  phase_end = tick &&
				(cnt_q == 10'(`CIDFS_FRAME_BITS - 1));
			cidfs_pkg::CIDFS_FLAG:  phase_end = tick &&
				(cnt_q == {2'b00, cfg.flag_bit_count} - 10'h001);
			default:                phase_end = 1'b0;
		endcase
	end

	// Next phase; empty phases are skipped in a single step
	always_comb begin
		state_d = state_q;
		byte_d  = byte_q;
		launch  = 1'b0;
		finish  = 1'b0;
		unique case (state_q)
			cidfs_pkg::CIDFS_IDLE: begin
				if (start_q && cfg.generator_on) begin
					launch = 1'b1;
					byte_d = '0;
					if (cfg.seizure_half_count != 8'h00) begin
						state_d = cidfs_pkg::CIDFS_SEIZE;
					end else if (cfg.mark_bit_count != 8'h00) begin
						state_d = cidfs_pkg::CIDFS_MARK;
					end else if (eff_len != 7'h00) begin
						state_d = cidfs_pkg::CIDFS_DATA;
					end else begin
						finish = 1'b1;
					end
				end
			end
			cidfs_pkg::CIDFS_SEIZE: begin
				if (phase_end) begin
					if (cfg.mark_bit_count != 8'h00) begin
						state_d = cidfs_pkg::CIDFS_MARK;
					end else if (eff_len != 7'h00) begin
						state_d = cidfs_pkg::CIDFS_DATA;
					end else begin
						finish = 1'b1;
					end
				end
			end
			cidfs_pkg::CIDFS_MARK: begin
				if (phase_end) begin
					if (eff_len != 7'h00) begin
						state_d = cidfs_pkg::CIDFS_DATA;
					end else begin
						finish = 1'b1;
					end
				end
			end
			cidfs_pkg::CIDFS_DATA: begin
				if (phase_end) begin
					if ({1'b0, byte_q} == 7'(eff_len - 7'h01)) begin
						finish = 1'b1;
					end else if (cfg.flag_bit_count != 8'h00) begin
						state_d = cidfs_pkg::CIDFS_FLAG;
					end else begin
						byte_d = byte_q + 1'b1;
					end
				end
			end
			cidfs_pkg::CIDFS_FLAG: begin
				if (phase_end) begin
					state_d = cidfs_pkg::CIDFS_DATA;
					byte_d  = byte_q + 1'b1;
				end
			end
			cidfs_pkg::CIDFS_TRAIL: begin
				if (stop_req) begin
					state_d = cidfs_pkg::CIDFS_IDLE;
				end
			end
		endcase
		if (finish) begin
			state_d = cfg.trailing_mark_enable ?
				cidfs_pkg::CIDFS_TRAIL : cidfs_pkg::CIDFS_IDLE;
		end
		if (!cfg.generator_on) begin
			state_d = cidfs_pkg::CIDFS_IDLE;
		end
	end

	// Phase register and byte pointer
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= cidfs_pkg::CIDFS_IDLE;
			byte_q  <= '0;
		end else begin
			state_q <= state_d;
			byte_q  <= byte_d;
		end
	end

	// Bit counter within a phase, restarted on every phase change
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= 10'h000;
		end else if (state_d != state_q || phase_end || launch) begin
			cnt_q <= 10'h000;
		end else if (tick) begin
			cnt_q <= cnt_q + 10'h001;
		end
	end

	// Start bit: a software write wins over the self-clear
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			start_q <= 1'b0;
		end else if (state_q == cidfs_pkg::CIDFS_TRAIL && stop_req) begin
			start_q <= 1'b0;
		end else if (ctrl_wr) begin
			start_q <= i_reg_wdata[`CIDFS_CTRL_START];
		end else if (finish) begin
			start_q <= 1'b0;
		end
	end

	// Bit of the current phase; frame is start 0, byte LSB first, stop 1
	always_comb begin
		cur_bit = 1'b1;
		unique case (state_q)
			cidfs_pkg::CIDFS_SEIZE: cur_bit = cnt_q[0];
			cidfs_pkg::CIDFS_DATA: begin
				if (cnt_q == 10'h000) begin
					cur_bit = 1'b0;
				end else if (cnt_q < 10'(`CIDFS_FRAME_BITS - 1)) begin
					cur_bit = rd_byte[3'(cnt_q - 10'h001)];
				end else begin
					cur_bit = 1'b1;
				end
			end
			default: cur_bit = 1'b1;
		endcase
	end

	// Registered outputs, one cycle behind the phase machine
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_fsk_bit    <= 1'b1;
			o_fsk_active <= 1'b0;
		end else begin
			o_fsk_bit    <= cur_bit;
			o_fsk_active <= state_q != cidfs_pkg::CIDFS_IDLE;
		end
	end

	// Channel route, one-hot per channel
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			always_ff @(posedge i_core_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					o_chan_en[gi] <= 1'b0;
				end else begin
					o_chan_en[gi] <= (state_q != cidfs_pkg::CIDFS_IDLE) &&
						(cfg.generator_channel_select == 2'(gi));
				end
			end
		end
	endgenerate

	assign o_std_select = cfg.standard_select;
	assign o_busy       = start_q;

	// Checks
	flag_run_len_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		(state_q == cidfs_pkg::CIDFS_FLAG && tick && cfg.generator_on &&
		 cnt_q == {2'b00, cfg.flag_bit_count} - 10'h001)
		|=> state_q == cidfs_pkg::CIDFS_DATA)
		else $error("flag run did not end at its length");
	byte_cap_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_DATA |-> {1'b0, byte_q} < eff_len)
		else $error("byte pointer beyond capped length");
	no_data_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		eff_len == 7'h00 |-> state_q != cidfs_pkg::CIDFS_DATA)
		else $error("data sent with zero length");
	seize_pair_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_SEIZE && tick && !phase_end &&
		cfg.generator_on |=> ##1 o_fsk_bit != $past(o_fsk_bit))
		else $error("seizure bits did not alternate");
	mark_ones_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_MARK |=> o_fsk_bit && o_fsk_active)
		else $error("mark phase sent a zero");
	chan_route_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		o_fsk_active |-> $onehot(o_chan_en))
		else $error("channel route not one-hot");
	gen_off_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		!cfg.generator_on |=> state_q == cidfs_pkg::CIDFS_IDLE ##1
		!o_fsk_active)
		else $error("generator ran while disabled");
	mute_end_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		finish && !cfg.trailing_mark_enable |=> ##1 !o_fsk_active)
		else $error("output not muted after message");
	trail_ones_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_TRAIL && !stop_req && cfg.generator_on
		|=> state_q == cidfs_pkg::CIDFS_TRAIL ##1 o_fsk_bit)
		else $error("trailing mark stream broke");
	trail_stop_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_TRAIL && stop_req
		|=> state_q == cidfs_pkg::CIDFS_IDLE && !start_q)
		else $error("trailing stream not stopped");
	start_clear_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		finish && !ctrl_wr |=> !start_q)
		else $error("start bit not self-cleared");
	zero_start_a: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn)
		state_q == cidfs_pkg::CIDFS_IDLE && start_q && cfg.generator_on &&
		cfg.seizure_half_count == 8'h00 && cfg.mark_bit_count == 8'h00 &&
		eff_len == 7'h00 && !ctrl_wr |=> !start_q)
		else $error("start bit held with all counts zero");
endmodule : cidfs_seq

// ==== core/cidfs_defs.svh ====
// Register offsets, field positions, reset values and timing counts of
// the caller-ID message sequencer. Definitions only; included by name.
`ifndef CIDFS_DEFS_SVH
`define CIDFS_DEFS_SVH

// Register offsets (command byte bits 6:0); bit 7 of the command is write
`define CIDFS_CMD_WRITE_BIT   7
`define CIDFS_ADDR_FLAG       7'h2C
`define CIDFS_ADDR_DATA       7'h2D
`define CIDFS_ADDR_SEIZE      7'h2E
`define CIDFS_ADDR_MARK       7'h2F
`define CIDFS_ADDR_CTRL       7'h30

// Control register fields
`define CIDFS_CTRL_START      0
`define CIDFS_CTRL_TRAIL      1
`define CIDFS_CTRL_STD        2
`define CIDFS_CTRL_ON         3
`define CIDFS_CTRL_CHAN_LO    4
`define CIDFS_CTRL_CHAN_HI    5

// Reset values
`define CIDFS_LEN_RESET       8'h00
`define CIDFS_CHAN_RESET      2'h0

// Message limits and frame shape
`define CIDFS_MAX_BYTES       64
`define CIDFS_FRAME_BITS      10

// Bit timing: one bit at 1200 baud, core clock in MHz
`define CIDFS_CLK_MHZ         20
`define CIDFS_BIT_TIME_NS     833333
`define CIDFS_BIT_CYCLES      ((`CIDFS_BIT_TIME_NS * `CIDFS_CLK_MHZ) / 1000)

`endif

// ==== core/cidfs_pkg.sv ====
// Types shared by the caller-ID message sequencer files.
// Assumes nothing of its surroundings.
package cidfs_pkg;

	// Sequencer phases
	typedef enum logic [2:0] {
		CIDFS_IDLE,
		CIDFS_SEIZE,
		CIDFS_MARK,
		CIDFS_DATA,
		CIDFS_FLAG,
		CIDFS_TRAIL
	} cidfs_state_t;

	// Software settings held by the register port
	typedef struct packed {
		logic [7:0] flag_bit_count;
		logic [7:0] message_byte_count;
		logic [7:0] seizure_half_count;
		logic [7:0] mark_bit_count;
		logic [1:0] generator_channel_select;
		logic       generator_on;
		logic       standard_select;
		logic       trailing_mark_enable;
	} cidfs_cfg_t;

endpackage : cidfs_pkg

// ==== core/cidfs_reg_port.sv ====
// Command-byte register port of the caller-ID sequencer.
// Assumes one command with its data per i_valid cycle, synchronous inputs.
`timescale 1ns/1ps
`include "cidfs_defs.svh"

module cidfs_reg_port (
	input  wire logic              i_core_clk,    // Core clock
	input  wire logic              i_resetn,      // Async reset, low
	input  wire logic              i_valid,       // Command present
	input  wire logic [7:0]        i_cmd,         // Bit 7 write, 6:0 addr
	input  wire logic [7:0]        i_wdata,       // Write data
	input  wire logic              i_start,       // Live start bit
	output cidfs_pkg::cidfs_cfg_t  o_cfg,         // Stored settings
	output logic                   o_ctrl_wr,     // Control write pulse
	output logic [7:0]             o_rdata,       // Read data
	output logic                   o_rvalid       // Read data valid
);
	logic       wr;
	logic [6:0] addr;

	assign wr   = i_valid && i_cmd[`CIDFS_CMD_WRITE_BIT];
	assign addr = i_cmd[6:0];
	assign o_ctrl_wr = wr && (addr == `CIDFS_ADDR_CTRL);

	// Length and control storage; start bit lives in the sequencer
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cfg.flag_bit_count           <= `CIDFS_LEN_RESET;
			o_cfg.message_byte_count       <= `CIDFS_LEN_RESET;
			o_cfg.seizure_half_count       <= `CIDFS_LEN_RESET;
			o_cfg.mark_bit_count           <= `CIDFS_LEN_RESET;
			o_cfg.generator_channel_select <= `CIDFS_CHAN_RESET;
			o_cfg.generator_on             <= 1'b0;
			o_cfg.standard_select          <= 1'b0;
			o_cfg.trailing_mark_enable     <= 1'b0;
		end else if (wr) begin
			unique case (addr)
				`CIDFS_ADDR_FLAG:  o_cfg.flag_bit_count     <= i_wdata;
				`CIDFS_ADDR_DATA:  o_cfg.message_byte_count <= i_wdata;
				`CIDFS_ADDR_SEIZE: o_cfg.seizure_half_count <= i_wdata;
				`CIDFS_ADDR_MARK:  o_cfg.mark_bit_count     <= i_wdata;
				`CIDFS_ADDR_CTRL: begin
					o_cfg.generator_channel_select <=
						i_wdata[`CIDFS_CTRL_CHAN_HI:`CIDFS_CTRL_CHAN_LO];
					o_cfg.generator_on  <= i_wdata[`CIDFS_CTRL_ON];
					o_cfg.standard_select <= i_wdata[`CIDFS_CTRL_STD];
					o_cfg.trailing_mark_enable <= i_wdata[`CIDFS_CTRL_TRAIL];
				end
				default: ;
			endcase
		end
	end

	// Read answer one cycle after the command; unmapped reads give zero
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_valid && !i_cmd[`CIDFS_CMD_WRITE_BIT];
			unique case (addr)
				`CIDFS_ADDR_FLAG:  o_rdata <= o_cfg.flag_bit_count;
				`CIDFS_ADDR_DATA:  o_rdata <= o_cfg.message_byte_count;
				`CIDFS_ADDR_SEIZE: o_rdata <= o_cfg.seizure_half_count;
				`CIDFS_ADDR_MARK:  o_rdata <= o_cfg.mark_bit_count;
				`CIDFS_ADDR_CTRL:  o_rdata <= {2'b00,
					o_cfg.generator_channel_select, o_cfg.generator_on,
					o_cfg.standard_select, o_cfg.trailing_mark_enable,
					i_start};
				default:           o_rdata <= 8'h00;
			endcase
		end
	end
endmodule : cidfs_reg_port

// ==== core/cidfs_msg_mem.sv ====
// Message memory of the caller-ID sequencer: one write port, one
// registered read port. Contents are undefined after reset.
`timescale 1ns/1ps
`include "cidfs_defs.svh"

module cidfs_msg_mem #(
	parameter int DEPTH = `CIDFS_MAX_BYTES
) (
	input  wire logic                     i_core_clk, // Core clock
	input  wire logic                     i_wr,       // Write strobe
	input  wire logic [$clog2(DEPTH)-1:0] i_waddr,    // Write address
	input  wire logic [7:0]               i_wdata,    // Write byte
	input  wire logic [$clog2(DEPTH)-1:0] i_raddr,    // Read address
	output logic [7:0]                    o_rdata     // Byte, one cycle later
);
	logic [7:0] mem [DEPTH];

	// No reset on the array so it maps to plain RAM
	always_ff @(posedge i_core_clk) begin
		if (i_wr) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule : cidfs_msg_mem

// ==== test/cidfs_line_rx.sv ====
// Line-side receiver model: samples the caller-ID serial bit mid-bit.
// Assumes each bit lasts BIT_CYCLES clocks from the rise of i_active.
`timescale 1ns/1ps

module cidfs_line_rx #(
	parameter int BIT_CYCLES = 4
) (
	input  wire logic i_core_clk, // Core clock
	input  wire logic i_resetn,   // Async reset, low
	input  wire logic i_clear,    // Forget captured bits
	input  wire logic i_bit,      // Serial bit from design
	input  wire logic i_active    // Line unmuted
);
	logic bits [0:1023]; // Captured bits in arrival order
	int   n_bits;        // Bits captured so far
	int   cnt;           // Cycle within the current bit

	// Mid-bit sampling rides out a one-cycle skew at bit edges
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			n_bits <= 0;
			cnt    <= 0;
		end else if (i_clear) begin
			n_bits <= 0;
			cnt    <= 0;
		end else if (!i_active) begin
			cnt <= 0; // Muted line carries no bits
		end else begin
			cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
			if (cnt == BIT_CYCLES / 2 && n_bits < 1024) begin
				bits[n_bits] <= i_bit;
				n_bits       <= n_bits + 1;
			end
		end
	end
endmodule : cidfs_line_rx

// ==== test/cidfs_seq_tb.sv ====
// Testbench of the caller-ID sequencer: register, memory and stream tests.
// Assumes the line receiver model and a short bit time in simulation.
`timescale 1ns/1ps

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cidfs_seq_tb;
	localparam int BC = 4; // Short bit time keeps the run brief

	logic       core_clk;
	logic       resetn;
	logic       reg_valid;
	logic [7:0] reg_cmd;
	logic [7:0] reg_wdata;
	logic [7:0] rdata;
	logic       rvalid;
	logic       mem_wr;
	logic [5:0] mem_addr;
	logic [7:0] mem_wdata;
	logic       fsk_bit;
	logic       fsk_active;
	logic [3:0] chan_en;
	logic       std_sel;
	logic       busy;
	logic       rx_clear;
	logic       exp_q [$];
	int         errors;
	int         n_tests;

	cidfs_seq #(.BIT_CYCLES(BC)) cidfs_seq_inst (
		.i_core_clk(core_clk), .i_resetn(resetn),
		.i_reg_valid(reg_valid), .i_reg_cmd(reg_cmd),
		.i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr),
		.i_mem_wdata(mem_wdata), .o_fsk_bit(fsk_bit),
		.o_fsk_active(fsk_active), .o_chan_en(chan_en),
		.o_std_select(std_sel), .o_busy(busy));

	cidfs_line_rx #(.BIT_CYCLES(BC)) cidfs_line_rx_inst (
		.i_core_clk(core_clk), .i_resetn(resetn), .i_clear(rx_clear),
		.i_bit(fsk_bit), .i_active(fsk_active));

	// Free-running 20 MHz core clock
	always #25 core_clk = ~core_clk;

	task automatic test_done;
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic give_up;
		errors++;
		test_done;
	endtask : give_up

	// One command per call; valid drops for a cycle between calls
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_valid = 1'b1;
		reg_cmd   = {1'b1, a};
		reg_wdata = d;
		@(negedge core_clk);
		reg_valid = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		int k;
		@(negedge core_clk);
		reg_valid = 1'b1;
		reg_cmd   = {1'b0, a};
		@(negedge core_clk);
		reg_valid = 1'b0;
		for (k = 0; k < 3 && rvalid !== 1'b1; k++)
			@(negedge core_clk);
		if (k == 3)
			give_up;
		`CHK(rdata, e)
	endtask : rd_chk

	task automatic mem_put(input logic [5:0] a, input logic [7:0] d);
		@(negedge core_clk);
		mem_wr    = 1'b1;
		mem_addr  = a;
		mem_wdata = d;
		@(negedge core_clk);
		mem_wr = 1'b0;
	endtask : mem_put

	task automatic wait_act(input logic v, input int lim);
		int k;
		for (k = 0; k < lim && fsk_active !== v; k++)
			@(negedge core_clk);
		if (k == lim)
			give_up;
	endtask : wait_act

	task automatic wait_idle(input int lim);
		int k;
		for (k = 0; k < lim && busy !== 1'b0; k++)
			@(negedge core_clk);
		if (k == lim)
			give_up;
	endtask : wait_idle

	// Sets the four counts, clears the receiver and the expectation
	task automatic setup(input logic [7:0] fl, dl, sl, ml);
		wr(7'h2C, fl);
		wr(7'h2D, dl);
		wr(7'h2E, sl);
		wr(7'h2F, ml);
		@(negedge core_clk);
		rx_clear = 1'b1;
		@(negedge core_clk);
		rx_clear = 1'b0;
		exp_q.delete();
	endtask : setup

	task automatic push_ones(input int n);
		repeat (n) exp_q.push_back(1'b1);
	endtask : push_ones

	// Framed byte: start 0, data LSB first, stop 1
	task automatic push_byte(input logic [7:0] b);
		exp_q.push_back(1'b0);
		for (int i = 0; i < 8; i++)
			exp_q.push_back(b[i]);
		exp_q.push_back(1'b1);
	endtask : push_byte

	task automatic cmp_stream;
		`CHK(cidfs_line_rx_inst.n_bits, exp_q.size())
		for (int i = 0; i < exp_q.size(); i++)
			`CHK(cidfs_line_rx_inst.bits[i], exp_q[i])
	endtask : cmp_stream

	task automatic t_reset;
		for (int a = 8'h2C; a <= 8'h30; a++)
			rd_chk(a[6:0], 8'h00);
		`CHK({busy, fsk_active, chan_en}, 6'h00)
		`CHK(std_sel, 1'b0)
	endtask : t_reset

	task automatic t_regs;
		for (int a = 8'h2C; a <= 8'h2F; a++)
			wr(a[6:0], 8'hA0 ^ a[7:0]);
		for (int a = 8'h2C; a <= 8'h2F; a++)
			rd_chk(a[6:0], 8'hA0 ^ a[7:0]);
		wr(7'h2B, 8'h77);
		rd_chk(7'h2B, 8'h00);
		wr(7'h30, 8'hF4);
		rd_chk(7'h30, 8'h34);
		`CHK(std_sel, 1'b1)
		wr(7'h30, 8'h00);
	endtask : t_regs

	// Over-long count sends exactly 64 bytes in address order
	task automatic t_long;
		for (int i = 0; i < 64; i++)
			mem_put(i[5:0], 8'h5A ^ i[7:0]);
		setup(8'h00, 8'h46, 8'h00, 8'h00);
		for (int i = 0; i < 64; i++)
			push_byte(8'h5A ^ i[7:0]);
		wr(7'h30, 8'h09);
		wait_act(1'b1, 10);
		wait_act(1'b0, 3000);
		cmp_stream;
		`CHK(busy, 1'b0)
	endtask : t_long

	task automatic t_frame;
		mem_put(6'h00, 8'hA5);
		mem_put(6'h01, 8'h3C);
		setup(8'h03, 8'h02, 8'h01, 8'h02);
		repeat (2) push_byte(8'h00);
		exp_q.delete();
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back(1'b0);
			exp_q.push_back(1'b1);
		end
		push_ones(2);
		push_byte(8'hA5);
		push_ones(3);
		push_byte(8'h3C);
		wr(7'h30, 8'h29);
		wait_act(1'b1, 10);
		`CHK(chan_en, 4'h4)
		wait_act(1'b0, 400);
		cmp_stream;
		`CHK({busy, chan_en}, 5'h00)
	endtask : t_frame

	task automatic t_zero;
		setup(8'h05, 8'h00, 8'h00, 8'h00);
		wr(7'h30, 8'h09);
		wait_idle(4);
		repeat (8) @(negedge core_clk);
		`CHK(cidfs_line_rx_inst.n_bits, 0)
	endtask : t_zero

	task automatic t_trail;
		setup(8'h00, 8'h01, 8'h00, 8'h00);
		wr(7'h30, 8'h0B);
		wait_act(1'b1, 10);
		wait_idle(100);
		repeat (40) @(negedge core_clk);
		`CHK(fsk_active, 1'b1)
		push_byte(8'hA5);
		push_ones(cidfs_line_rx_inst.n_bits - 10);
		cmp_stream;
		wr(7'h30, 8'h09);
		wait_act(1'b0, 4);
		`CHK(busy, 1'b0)
	endtask : t_trail

	// Switching the generator off aborts but keeps the start bit
	task automatic t_off;
		setup(8'h00, 8'h00, 8'h0A, 8'h00);
		wr(7'h30, 8'h09);
		wait_act(1'b1, 10);
		repeat (12) @(negedge core_clk);
		wr(7'h30, 8'h01);
		wait_act(1'b0, 4);
		rd_chk(7'h30, 8'h01);
		wr(7'h30, 8'h00);
	endtask : t_off

	task automatic t_chan;
		logic [7:0] c;
		setup(8'h00, 8'h00, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			c = {2'b00, i[1:0], 1'b1, i[0], 2'b11};
			wr(7'h30, c);
			wait_act(1'b1, 10);
			`CHK(chan_en, 4'h1 << i)
			`CHK(std_sel, i[0])
			wr(7'h30, c & 8'hFD);
			wait_act(1'b0, 4);
		end
		wr(7'h30, 8'h00);
	endtask : t_chan

	initial begin
		core_clk  = 1'b0;
		resetn    = 1'b0;
		reg_valid = 1'b0;
		reg_cmd   = 8'h00;
		reg_wdata = 8'h00;
		mem_wr    = 1'b0;
		mem_addr  = 6'h00;
		mem_wdata = 8'h00;
		rx_clear  = 1'b0;
		errors    = 0;
		n_tests   = 0;
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		t_reset;
		t_regs;
		t_long;
		t_frame;
		t_zero;
		t_trail;
		t_off;
		t_chan;
		test_done;
	end
endmodule : cidfs_seq_tb
